// file: core/mppc_regs.svh
// Register offsets, field positions and reset values of the port pin controller.
// Assumes word-indexed plain register port with 8-bit data.
`ifndef MPPC_REGS_SVH
`define MPPC_REGS_SVH

`define MPPC_A_P1_OUT    6'h00
`define MPPC_A_P1_DIR    6'h01
`define MPPC_A_P1_PLU    6'h02
`define MPPC_A_P1_ODC    6'h03
`define MPPC_A_P1_OMD    6'h04
`define MPPC_A_P1_IN     6'h05
`define MPPC_A_P3_OUT    6'h08
`define MPPC_A_P3_DIR    6'h09
`define MPPC_A_P3_PLU    6'h0A
`define MPPC_A_P3_ODC    6'h0B
`define MPPC_A_P3_IN     6'h0D
`define MPPC_A_P5_OUT    6'h10
`define MPPC_A_P5_DIR    6'h11
`define MPPC_A_P5_PLU    6'h12
`define MPPC_A_P5_OMD    6'h14
`define MPPC_A_P5_IN     6'h15
`define MPPC_A_P7_OUT    6'h18
`define MPPC_A_P7_DIR    6'h19
`define MPPC_A_P7_PLU    6'h1A
`define MPPC_A_P7_ODC    6'h1B
`define MPPC_A_P7_OMD    6'h1C
`define MPPC_A_P7_IN     6'h1D
`define MPPC_A_P9_OUT    6'h20
`define MPPC_A_P9_DIR    6'h21
`define MPPC_A_P9_PLU    6'h22
`define MPPC_A_P9_IN     6'h25
`define MPPC_A_PA_OUT    6'h28
`define MPPC_A_PA_DIR    6'h29
`define MPPC_A_PA_PLU    6'h2A
`define MPPC_A_PA_ODC    6'h2B
`define MPPC_A_PA_IN     6'h2D
`define MPPC_A_PULL_POLARITY_SELECT     6'h30
`define MPPC_A_LOW_OSC_PIN_SELECT      6'h31
`define MPPC_A_RST_BIT   6'h32
`define MPPC_A_STATUS    6'h33

`define MPPC_PULL_POLARITY_SELECT_P1    0
`define MPPC_PULL_POLARITY_SELECT_P7    1
`define MPPC_RST_BIT     7
`define MPPC_ST_RSTPEND  0
`define MPPC_ST_CLKOK    1

`define MPPC_RV_ZERO     8'h00
`define MPPC_RV_P1_PLU   8'h03
`define MPPC_RV_P9_PLU   8'h01
`define MPPC_RV_OUT      8'hFF
`define MPPC_RV_RST      8'h80

// Width of the 7-bit ports
`define MPPC_W7          7
// Stabilisation wait after reset pin release, in ns and in cycles at 10 ns
`define MPPC_STAB_NS     1000
`define MPPC_CLK_NS      10
`define MPPC_STAB_CYC    ((`MPPC_STAB_NS + `MPPC_CLK_NS - 1) / `MPPC_CLK_NS)
// Cycles a software reset drives the reset pin low
`define MPPC_SWRST_CYC   16

`endif

// file: core/mppc_pkg.sv
// Types shared by the port pin controller.
// Assumes mppc_regs.svh for all numbers.
package mppc_pkg;

   typedef struct packed
   {
      logic [7:0] dir;
      logic [7:0] plu;
      logic [7:0] odc;
      logic [7:0] omd;
      logic [7:0] out;
   } mppc_cfg_type;

   typedef struct packed
   {
      logic [7:0] o;
      logic [7:0] oe;
      logic [7:0] pu;
      logic [7:0] pd;
   } mppc_pad_type;

   typedef enum logic [1:0]
   {
      MPPC_RUN,
      MPPC_SWRST,
      MPPC_WAIT
   } mppc_rst_state_type;

endpackage

// file: core/mppc_pin_bank.sv
// One 8-bit port bank: pad drive, enables and pulls from its settings.
// Assumes function outputs and serial take-over come from outside.
`timescale 1ns/1ps
module mppc_pin_bank
   import mppc_pkg::*;
(
   input  wire mppc_cfg_type cfg,
   input  wire logic [7:0]   fn_out,
   input  wire logic [7:0]   ser_own,
   input  wire logic         pull_down,
   output mppc_pad_type      pad
);
   wire logic [7:0] fn_sel;
   wire logic [7:0] drv;
   wire logic [7:0] od;

   // Function drives only when selected and the pin is output
   assign fn_sel = (cfg.omd | ser_own) & cfg.dir;
   // Latch kept; function replaces it only on the pad
   assign drv    = (fn_sel & fn_out) | (~fn_sel & cfg.out);
   assign od     = cfg.odc;
   assign pad.o  = drv & ~od;
   // Open-drain drives only the low level
   assign pad.oe = cfg.dir & (~od | ~drv);
   // Whole port is either pull-up or pull-down
   assign pad.pu = pull_down ? 8'h00 : cfg.plu;
   assign pad.pd = pull_down ? cfg.plu : 8'h00;
endmodule

// file: core/mppc_rst_ctrl.sv
// Reset pin controller: software reset drive and clock stabilisation wait.
// Assumes the reset pin input is already synchronous.
`timescale 1ns/1ps
`include "mppc_regs.svh"
module mppc_rst_ctrl
   import mppc_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic rstn,
   input  wire logic sw_reset,
   input  wire logic reset_pin_n_i,
   output logic      reset_pin_n_oe,
   output logic      core_reset_n
);
   mppc_rst_state_type st_q;
   mppc_rst_state_type st_d;
   logic [9:0]         cnt_q;
   logic [9:0]         cnt_d;
   wire  logic         cnt_done;

   assign cnt_done = (cnt_q == 10'h000);

   always_comb
   begin
      st_d  = st_q;
      cnt_d = cnt_done ? cnt_q : cnt_q - 10'h001;
      case (st_q)
         MPPC_RUN:
         begin
            if (sw_reset)
            begin
               st_d  = MPPC_SWRST;
               cnt_d = 10'(`MPPC_SWRST_CYC - 1);
            end
            else if (!reset_pin_n_i)
            begin
               st_d  = MPPC_WAIT;
               cnt_d = 10'(`MPPC_STAB_CYC - 1);
            end
         end
         MPPC_SWRST:
         begin
            if (cnt_done)
            begin
               st_d  = MPPC_WAIT;
               cnt_d = 10'(`MPPC_STAB_CYC - 1);
            end
         end
         MPPC_WAIT:
         begin
            // Pin held low restarts the wait
            if (!reset_pin_n_i)
               cnt_d = 10'(`MPPC_STAB_CYC - 1);
            else if (cnt_done)
               st_d = MPPC_RUN;
         end
         default:
            st_d = MPPC_RUN;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         st_q  <= MPPC_WAIT;
         cnt_q <= 10'(`MPPC_STAB_CYC - 1);
      end
      else
      begin
         st_q  <= st_d;
         cnt_q <= cnt_d;
      end
   end

   // N-channel open drain: only ever pulls the pin low
   assign reset_pin_n_oe = (st_q == MPPC_SWRST);
   assign core_reset_n   = (st_q == MPPC_RUN);
endmodule

// file: core/mppc_port_ctrl.sv
// Port pin controller top: register file on a plain strobe port and pad control.
// Assumes pads resolve o/oe/pull signals externally and inputs are synchronous.
`timescale 1ns/1ps
`include "mppc_regs.svh"
module mppc_port_ctrl
   import mppc_pkg::*;
(
   input  wire logic         sys_clk,
   input  wire logic         rstn,
   input  wire logic [5:0]   reg_addr,
   input  wire logic [7:0]   reg_wdata,
   input  wire logic         reg_wr,
   input  wire logic         reg_rd,
   output logic      [7:0]   reg_rdata,
   input  wire logic [7:0]   fn_out_p1,
   input  wire logic [7:0]   fn_out_p3,
   input  wire logic [7:0]   fn_out_p5,
   input  wire logic [7:0]   fn_out_p7,
   input  wire logic [7:0]   fn_out_pa,
   input  wire logic [7:0]   ser_own_p1,
   input  wire logic [7:0]   ser_own_p3,
   input  wire logic [7:0]   ser_own_p7,
   input  wire logic [7:0]   ser_own_pa,
   input  wire logic [7:0]   pin_in_p1,
   input  wire logic [7:0]   pin_in_p3,
   input  wire logic [7:0]   pin_in_p5,
   input  wire logic [7:0]   pin_in_p7,
   input  wire logic [7:0]   pin_in_p9,
   input  wire logic [7:0]   pin_in_pa,
   output mppc_pad_type      pad_p1,
   output mppc_pad_type      pad_p3,
   output mppc_pad_type      pad_p5,
   output mppc_pad_type      pad_p7,
   output mppc_pad_type      pad_p9,
   output mppc_pad_type      pad_pa,
   output logic              low_osc_pin_select,
   input  wire logic         reset_pin_n_i,
   output logic              reset_pin_n_o,
   output logic              reset_pin_n_oe,
   input  wire logic         memory_mode_pin,
   output logic              core_reset_n
);
   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   mppc_cfg_type p1_q, p3_q, p5_q, p7_q, p9_q, pa_q;
   logic [1:0]   pull_polarity_select_q;
   logic         low_osc_pin_select_q;
   logic [7:0]   rdata_q;
   logic [7:0]   rdata_d;

   // ------------------------------------------------------------
   // Write decode
   // ------------------------------------------------------------
   wire logic    sw_reset;
   wire logic    rst_pending;

   // Writing 0 to the reset bit starts a software reset
   assign sw_reset = reg_wr & (reg_addr == `MPPC_A_RST_BIT) & ~reg_wdata[`MPPC_RST_BIT];

   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         p1_q <= '{dir: `MPPC_RV_ZERO, plu: `MPPC_RV_P1_PLU, odc: `MPPC_RV_ZERO,
                   omd: `MPPC_RV_ZERO, out: `MPPC_RV_OUT};
         p3_q <= '{dir: `MPPC_RV_ZERO, plu: `MPPC_RV_ZERO, odc: `MPPC_RV_ZERO,
                   omd: `MPPC_RV_ZERO, out: `MPPC_RV_OUT};
         p5_q <= '{dir: `MPPC_RV_ZERO, plu: `MPPC_RV_ZERO, odc: `MPPC_RV_ZERO,
                   omd: `MPPC_RV_ZERO, out: `MPPC_RV_OUT};
         p7_q <= '{dir: `MPPC_RV_ZERO, plu: `MPPC_RV_ZERO, odc: `MPPC_RV_ZERO,
                   omd: `MPPC_RV_ZERO, out: `MPPC_RV_OUT};
         p9_q <= '{dir: `MPPC_RV_ZERO, plu: `MPPC_RV_P9_PLU, odc: `MPPC_RV_ZERO,
                   omd: `MPPC_RV_ZERO, out: `MPPC_RV_OUT};
         pa_q <= '{dir: `MPPC_RV_ZERO, plu: `MPPC_RV_ZERO, odc: `MPPC_RV_ZERO,
                   omd: `MPPC_RV_ZERO, out: `MPPC_RV_OUT};
         pull_polarity_select_q <= 2'h0;
         low_osc_pin_select_q                 <= 1'b0;
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            `MPPC_A_P1_OUT: p1_q.out <= reg_wdata;
            `MPPC_A_P1_DIR: p1_q.dir <= reg_wdata;
            `MPPC_A_P1_PLU: p1_q.plu <= reg_wdata;
            `MPPC_A_P1_ODC: p1_q.odc <= reg_wdata;
            `MPPC_A_P1_OMD: p1_q.omd <= reg_wdata;
            `MPPC_A_P3_OUT: p3_q.out <= reg_wdata;
            `MPPC_A_P3_DIR: p3_q.dir <= reg_wdata;
            `MPPC_A_P3_PLU: p3_q.plu <= reg_wdata;
            `MPPC_A_P3_ODC: p3_q.odc <= reg_wdata;
            `MPPC_A_P5_OUT: p5_q.out <= {1'b0, reg_wdata[`MPPC_W7-1:0]};
            `MPPC_A_P5_DIR: p5_q.dir <= {1'b0, reg_wdata[`MPPC_W7-1:0]};
            `MPPC_A_P5_PLU: p5_q.plu <= {1'b0, reg_wdata[`MPPC_W7-1:0]};
            `MPPC_A_P5_OMD: p5_q.omd <= {1'b0, reg_wdata[`MPPC_W7-1:0]};
            `MPPC_A_P7_OUT: p7_q.out <= reg_wdata;
            `MPPC_A_P7_DIR: p7_q.dir <= reg_wdata;
            `MPPC_A_P7_PLU: p7_q.plu <= reg_wdata;
            `MPPC_A_P7_ODC: p7_q.odc <= reg_wdata;
            `MPPC_A_P7_OMD: p7_q.omd <= reg_wdata;
            `MPPC_A_P9_OUT: p9_q.out <= {7'h00, reg_wdata[0]};
            `MPPC_A_P9_DIR: p9_q.dir <= {7'h00, reg_wdata[0]};
            `MPPC_A_P9_PLU: p9_q.plu <= {7'h00, reg_wdata[0]};
            `MPPC_A_PA_OUT: pa_q.out <= {1'b0, reg_wdata[`MPPC_W7-1:0]};
            `MPPC_A_PA_DIR: pa_q.dir <= {1'b0, reg_wdata[`MPPC_W7-1:0]};
            `MPPC_A_PA_PLU: pa_q.plu <= {1'b0, reg_wdata[`MPPC_W7-1:0]};
            `MPPC_A_PA_ODC: pa_q.odc <= {1'b0, reg_wdata[`MPPC_W7-1:0]};
            `MPPC_A_PULL_POLARITY_SELECT:  pull_polarity_select_q <= reg_wdata[1:0];
            `MPPC_A_LOW_OSC_PIN_SELECT:   low_osc_pin_select_q <= reg_wdata[0];
            default:        ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   always_comb
   begin
      case (reg_addr)
         `MPPC_A_P1_OUT: rdata_d = p1_q.out;
         `MPPC_A_P1_DIR: rdata_d = p1_q.dir;
         `MPPC_A_P1_PLU: rdata_d = p1_q.plu;
         `MPPC_A_P1_ODC: rdata_d = p1_q.odc;
         `MPPC_A_P1_OMD: rdata_d = p1_q.omd;
         `MPPC_A_P1_IN:  rdata_d = pin_in_p1;
         `MPPC_A_P3_OUT: rdata_d = p3_q.out;
         `MPPC_A_P3_DIR: rdata_d = p3_q.dir;
         `MPPC_A_P3_PLU: rdata_d = p3_q.plu;
         `MPPC_A_P3_ODC: rdata_d = p3_q.odc;
         `MPPC_A_P3_IN:  rdata_d = pin_in_p3;
         `MPPC_A_P5_OUT: rdata_d = p5_q.out;
         `MPPC_A_P5_DIR: rdata_d = p5_q.dir;
         `MPPC_A_P5_PLU: rdata_d = p5_q.plu;
         `MPPC_A_P5_OMD: rdata_d = p5_q.omd;
         `MPPC_A_P5_IN:  rdata_d = {1'b0, pin_in_p5[`MPPC_W7-1:0]};
         `MPPC_A_P7_OUT: rdata_d = p7_q.out;
         `MPPC_A_P7_DIR: rdata_d = p7_q.dir;
         `MPPC_A_P7_PLU: rdata_d = p7_q.plu;
         `MPPC_A_P7_ODC: rdata_d = p7_q.odc;
         `MPPC_A_P7_OMD: rdata_d = p7_q.omd;
         `MPPC_A_P7_IN:  rdata_d = pin_in_p7;
         `MPPC_A_P9_OUT: rdata_d = p9_q.out;
         `MPPC_A_P9_DIR: rdata_d = p9_q.dir;
         `MPPC_A_P9_PLU: rdata_d = p9_q.plu;
         `MPPC_A_P9_IN:  rdata_d = {7'h00, pin_in_p9[0]};
         `MPPC_A_PA_OUT: rdata_d = pa_q.out;
         `MPPC_A_PA_DIR: rdata_d = pa_q.dir;
         `MPPC_A_PA_PLU: rdata_d = pa_q.plu;
         `MPPC_A_PA_ODC: rdata_d = pa_q.odc;
         `MPPC_A_PA_IN:  rdata_d = {1'b0, pin_in_pa[`MPPC_W7-1:0]};
         `MPPC_A_PULL_POLARITY_SELECT:  rdata_d = {6'h00, pull_polarity_select_q};
         `MPPC_A_LOW_OSC_PIN_SELECT:   rdata_d = {7'h00, low_osc_pin_select_q};
         `MPPC_A_RST_BIT: rdata_d = {reset_pin_n_i, 7'h00};
         `MPPC_A_STATUS: rdata_d = {5'h00, memory_mode_pin, core_reset_n, rst_pending};
         default:        rdata_d = `MPPC_RV_ZERO;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
         rdata_q <= `MPPC_RV_ZERO;
      else
         rdata_q <= reg_rd ? rdata_d : `MPPC_RV_ZERO;
   end
   assign reg_rdata = rdata_q;

   // ------------------------------------------------------------
   // Pad banks
   // ------------------------------------------------------------
   wire mppc_cfg_type p3_cfg;
   wire mppc_cfg_type p9_cfg;
   wire mppc_pad_type p9_raw;

   // Port three has no output-mode register; serial take-over only
   assign p3_cfg = '{dir: p3_q.dir, plu: p3_q.plu, odc: p3_q.odc, omd: `MPPC_RV_ZERO, out: p3_q.out};
   assign p9_cfg = p9_q;

   mppc_pin_bank u_p1 (.cfg(p1_q), .fn_out(fn_out_p1), .ser_own(ser_own_p1),
      .pull_down(pull_polarity_select_q[`MPPC_PULL_POLARITY_SELECT_P1]), .pad(pad_p1));
   mppc_pin_bank u_p3 (.cfg(p3_cfg), .fn_out(fn_out_p3), .ser_own(ser_own_p3),
      .pull_down(1'b0), .pad(pad_p3));
   mppc_pin_bank u_p5 (.cfg(p5_q), .fn_out(fn_out_p5), .ser_own(8'h00),
      .pull_down(1'b0), .pad(pad_p5));
   mppc_pin_bank u_p7 (.cfg(p7_q), .fn_out(fn_out_p7), .ser_own(ser_own_p7),
      .pull_down(pull_polarity_select_q[`MPPC_PULL_POLARITY_SELECT_P7]), .pad(pad_p7));
   mppc_pin_bank u_p9 (.cfg(p9_cfg), .fn_out(8'h00), .ser_own(8'h00),
      .pull_down(1'b0), .pad(p9_raw));
   mppc_pin_bank u_pa (.cfg(pa_q), .fn_out(fn_out_pa), .ser_own(ser_own_pa),
      .pull_down(1'b0), .pad(pad_pa));

   // Oscillator mode releases the port nine pin entirely
   assign pad_p9 = low_osc_pin_select_q ? '0 : p9_raw;
   assign low_osc_pin_select = low_osc_pin_select_q;

   // ------------------------------------------------------------
   // Reset pin
   // ------------------------------------------------------------
   mppc_rst_ctrl u_rst (
      .sys_clk        (sys_clk),
      .rstn           (rstn),
      .sw_reset       (sw_reset),
      .reset_pin_n_i  (reset_pin_n_i),
      .reset_pin_n_oe (reset_pin_n_oe),
      .core_reset_n   (core_reset_n)
   );
   assign rst_pending   = reset_pin_n_oe;
   assign reset_pin_n_o = 1'b0;
endmodule

// file: sim/mppc_board_model.sv
// Board circuits on the port pins: external drivers, pull resolution, reset pin wire.
// Assumes pad structs from the controller and one external driver pattern for all ports.
`timescale 1ns/1ps
module mppc_board_model
   import mppc_pkg::*;
(
   input  wire logic         sys_clk,
   input  wire mppc_pad_type pad_p1,
   input  wire mppc_pad_type pad_p3,
   input  wire mppc_pad_type pad_p5,
   input  wire mppc_pad_type pad_p7,
   input  wire mppc_pad_type pad_p9,
   input  wire mppc_pad_type pad_pa,
   input  wire logic [7:0]   ext_drv,
   input  wire logic [7:0]   ext_en,
   input  wire logic         ext_rst_n,
   input  wire logic         reset_pin_n_o,
   input  wire logic         reset_pin_n_oe,
   output logic      [7:0]   pin_in_p1,
   output logic      [7:0]   pin_in_p3,
   output logic      [7:0]   pin_in_p5,
   output logic      [7:0]   pin_in_p7,
   output logic      [7:0]   pin_in_p9,
   output logic      [7:0]   pin_in_pa,
   output logic              reset_pin_n_i,
   output logic              memory_mode_pin
);
   // Undriven, unpulled pins wander every cycle
   logic [7:0] flt_q = 8'h55;

   always @(posedge sys_clk)
   begin
      flt_q <= ~flt_q;
   end

   function automatic logic [7:0] lvl(mppc_pad_type p, logic [7:0] e, logic [7:0] d, logic [7:0] f);
      lvl = (p.oe & p.o) | (~p.oe & e & d) | (~p.oe & ~e & (p.pu | (~p.pd & f)));
   endfunction

   always_comb
   begin
      pin_in_p1 = lvl(pad_p1, ext_en, ext_drv, flt_q);
      pin_in_p3 = lvl(pad_p3, ext_en, ext_drv, flt_q);
      pin_in_p5 = lvl(pad_p5, ext_en, ext_drv, flt_q);
      pin_in_p7 = lvl(pad_p7, ext_en, ext_drv, flt_q);
      pin_in_p9 = lvl(pad_p9, ext_en, ext_drv, flt_q);
      pin_in_pa = lvl(pad_pa, ext_en, ext_drv, flt_q);
   end

   // Wired reset pin with on-chip pull-up
   assign reset_pin_n_i   = ext_rst_n & ~(reset_pin_n_oe & ~reset_pin_n_o);
   assign memory_mode_pin = 1'b0;
endmodule

// file: sim/mppc_port_ctrl_checker.sv
// Port-level assertions of the port pin controller.
// Assumes binding to mppc_port_ctrl; one clock, synchronous active-low reset.
`timescale 1ns/1ps
`include "mppc_regs.svh"
module mppc_port_ctrl_checker
   import mppc_pkg::*;
(
   input  wire logic         sys_clk,
   input  wire logic         rstn,
   input  wire logic [5:0]   reg_addr,
   input  wire logic [7:0]   reg_wdata,
   input  wire logic         reg_wr,
   input  wire mppc_pad_type pad_p1,
   input  wire mppc_pad_type pad_p3,
   input  wire mppc_pad_type pad_p5,
   input  wire mppc_pad_type pad_p7,
   input  wire mppc_pad_type pad_p9,
   input  wire mppc_pad_type pad_pa,
   input  wire logic         low_osc_pin_select,
   input  wire logic         reset_pin_n_i,
   input  wire logic         reset_pin_n_o,
   input  wire logic         reset_pin_n_oe,
   input  wire logic         core_reset_n
);
   // ------------------------------------------------------------
   // Cycles the reset pin has stayed high out of reset
   // ------------------------------------------------------------
   logic [7:0] hi_cnt_q;
   logic [7:0] hi_cnt_d;
   assign hi_cnt_d = (!rstn || !reset_pin_n_i) ? 8'h00 : (hi_cnt_q == 8'hFF) ? hi_cnt_q : hi_cnt_q + 8'h01;

   always_ff @(posedge sys_clk)
   begin
      hi_cnt_q <= hi_cnt_d;
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   property p_p1_reset;
      $rose(rstn) |-> pad_p1.oe == 8'h00 && pad_p1.pu == 8'h03 && pad_p1.pd == 8'h00;
   endproperty
   a_p1_reset: assert property (p_p1_reset) else $error("port one reset state wrong");
   property p_p3_reset;
      $rose(rstn) |-> pad_p3.oe == 8'h00 && pad_p3.pd == 8'h00;
   endproperty
   a_p3_reset: assert property (p_p3_reset) else $error("port three reset state wrong");
   property p_p5_reset;
      $rose(rstn) |-> pad_p5.oe == 8'h00 && pad_p5.pu == 8'h00;
   endproperty
   a_p5_reset: assert property (p_p5_reset) else $error("port five reset state wrong");
   property p_p7_reset;
      $rose(rstn) |-> pad_p7.oe == 8'h00 && pad_p7.pu == 8'h00 && pad_p7.pd == 8'h00;
   endproperty
   a_p7_reset: assert property (p_p7_reset) else $error("port seven reset state wrong");
   property p_pa_reset;
      $rose(rstn) |-> pad_pa.oe == 8'h00 && pad_pa.pu == 8'h00 && pad_pa.pd == 8'h00;
   endproperty
   a_pa_reset: assert property (p_pa_reset) else $error("port a reset state wrong");
   property p_p9_reset;
      $rose(rstn) |-> pad_p9.pu == 8'h01 && !low_osc_pin_select;
   endproperty
   a_p9_reset: assert property (p_p9_reset) else $error("port nine reset state wrong");
   property p_osc_pin;
      low_osc_pin_select |-> pad_p9 == 32'h0000_0000;
   endproperty
   a_osc_pin: assert property (p_osc_pin) else $error("oscillator pin still driven");
   property p_no_mix;
      !((|pad_p1.pu) && (|pad_p1.pd)) && !((|pad_p7.pu) && (|pad_p7.pd));
   endproperty
   a_no_mix: assert property (p_no_mix) else $error("pull-up and pull-down mixed");
   property p_sw_reset;
      reg_wr && reg_addr == 6'h32 && !reg_wdata[7] && core_reset_n
      |=> (reset_pin_n_oe && !reset_pin_n_o && !core_reset_n)[*8] ##8 reset_pin_n_oe ##1 !reset_pin_n_oe;
   endproperty
   a_sw_reset: assert property (p_sw_reset) else $error("software reset pulse wrong");
   property p_pin_hold;
      !reset_pin_n_i |=> !core_reset_n;
   endproperty
   a_pin_hold: assert property (p_pin_hold) else $error("core released while pin low");
   property p_stab_wait;
      $rose(core_reset_n) |-> hi_cnt_q >= 8'h63;
   endproperty
   a_stab_wait: assert property (p_stab_wait) else $error("clock wait too short");
   property p_stab_bound;
      hi_cnt_q == 8'h6E && !reset_pin_n_oe |-> core_reset_n;
   endproperty
   a_stab_bound: assert property (p_stab_bound) else $error("core not released after wait");

   c_sw_reset: cover property ($rose(reset_pin_n_oe));
   c_osc_sel: cover property ($rose(low_osc_pin_select));
   c_pull_down: cover property (|pad_p1.pd);
endmodule

bind mppc_port_ctrl mppc_port_ctrl_checker u_chk
(
   .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .pad_p1(pad_p1), .pad_p3(pad_p3), .pad_p5(pad_p5), .pad_p7(pad_p7), .pad_p9(pad_p9), .pad_pa(pad_pa),
   .low_osc_pin_select(low_osc_pin_select), .reset_pin_n_i(reset_pin_n_i), .reset_pin_n_o(reset_pin_n_o),
   .reset_pin_n_oe(reset_pin_n_oe), .core_reset_n(core_reset_n)
);

// file: sim/test_mppc_port_ctrl.sv
// Self-checking bench of the port pin controller.
// Assumes the board model on the pins and a 100 MHz clock.
`timescale 1ns/1ps
`include "mppc_regs.svh"
module test_mppc_port_ctrl
   import mppc_pkg::*;
;
   logic         sys_clk = 1'b0;
   logic         rstn = 1'b0;
   logic [5:0]   reg_addr = 6'h00;
   logic [7:0]   reg_wdata = 8'h00;
   logic         reg_wr = 1'b0;
   logic         reg_rd = 1'b0;
   logic [7:0]   fn_v = 8'h00;
   logic [7:0]   ser_v = 8'h00;
   logic [7:0]   ext_drv = 8'h00;
   logic [7:0]   ext_en = 8'h00;
   logic         ext_rst_n = 1'b1;
   logic [7:0]   reg_rdata, pin_p1, pin_p3, pin_p5, pin_p7, pin_p9, pin_pa;
   mppc_pad_type pad_p1, pad_p3, pad_p5, pad_p7, pad_p9, pad_pa;
   logic         osc_sel, rp_i, rp_o, rp_oe, mm, core_n;
   int           err_total = 0;
   int           samples_checked = 0;
   int           n;

   mppc_port_ctrl DUT
   (
      .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fn_out_p1(fn_v), .fn_out_p3(fn_v), .fn_out_p5(fn_v),
      .fn_out_p7(fn_v), .fn_out_pa(fn_v), .ser_own_p1(ser_v), .ser_own_p3(ser_v), .ser_own_p7(ser_v),
      .ser_own_pa(ser_v), .pin_in_p1(pin_p1), .pin_in_p3(pin_p3), .pin_in_p5(pin_p5), .pin_in_p7(pin_p7),
      .pin_in_p9(pin_p9), .pin_in_pa(pin_pa), .pad_p1(pad_p1), .pad_p3(pad_p3), .pad_p5(pad_p5),
      .pad_p7(pad_p7), .pad_p9(pad_p9), .pad_pa(pad_pa), .low_osc_pin_select(osc_sel), .reset_pin_n_i(rp_i),
      .reset_pin_n_o(rp_o), .reset_pin_n_oe(rp_oe), .memory_mode_pin(mm), .core_reset_n(core_n)
   );

   mppc_board_model u_board
   (
      .sys_clk(sys_clk), .pad_p1(pad_p1), .pad_p3(pad_p3), .pad_p5(pad_p5), .pad_p7(pad_p7),
      .pad_p9(pad_p9), .pad_pa(pad_pa), .ext_drv(ext_drv), .ext_en(ext_en), .ext_rst_n(ext_rst_n),
      .reset_pin_n_o(rp_o), .reset_pin_n_oe(rp_oe), .pin_in_p1(pin_p1), .pin_in_p3(pin_p3),
      .pin_in_p5(pin_p5), .pin_in_p7(pin_p7), .pin_in_p9(pin_p9), .pin_in_pa(pin_pa),
      .reset_pin_n_i(rp_i), .memory_mode_pin(mm)
   );

   initial
   begin
      forever #5 sys_clk = ~sys_clk;
   end

   // ------------------------------------------------------------
   // Bus and compare helpers
   // ------------------------------------------------------------
   task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      #1;
   endtask

   task rdc(input logic [5:0] a, input logic [7:0] exp, input string name);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk(name, reg_rdata, exp);
   endtask

   // Counts cycles until the core leaves reset, bounded
   task wait_core(input int lo, input string name);
      n = 0;
      while (core_n !== 1'b1 && n < 400)
      begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      chk(name, {7'h00, n >= lo && n <= lo + 3}, 8'h01);
   endtask

   task end_of_test;
      $display("Mismatches %0d, comparisons %0d", err_total, samples_checked);
      if (err_total == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task t_reset_vals;
      wait_core(`MPPC_STAB_CYC, "release_wait");
      rdc(6'h01, 8'h00, "p1_dir");
      rdc(6'h02, 8'h03, "p1_plu");
      chk("p1_pulled", {6'h00, pin_p1[1:0]}, 8'h03);
      rdc(6'h09, 8'h00, "p3_dir");
      rdc(6'h12, 8'h00, "p5_plu");
      rdc(6'h1A, 8'h00, "p7_plu");
      rdc(6'h22, 8'h01, "p9_plu");
      rdc(6'h29, 8'h00, "pa_dir");
   endtask

   task t_dir_pull;
      wr(6'h01, 8'hA5);
      wr(6'h00, 8'h3C);
      chk("p1_oe", pad_p1.oe, 8'hA5);
      chk("p1_pins", pin_p1 & 8'hA5, 8'h24);
      wr(6'h01, 8'h00);
      wr(6'h02, 8'hF0);
      wr(6'h30, 8'h01);
      chk("p1_pd", pad_p1.pd, 8'hF0);
      chk("p1_pu", pad_p1.pu, 8'h00);
      chk("p1_low", pin_p1 & 8'hF0, 8'h00);
      wr(6'h1A, 8'h0F);
      wr(6'h30, 8'h02);
      chk("p1_pu_back", pad_p1.pu, 8'hF0);
      chk("p7_pd", pad_p7.pd, 8'h0F);
      wr(6'h30, 8'h00);
   endtask

   task t_narrow;
      wr(6'h0A, 8'hFF);
      wr(6'h30, 8'h03);
      chk("p3_pu", pad_p3.pu, 8'hFF);
      chk("p3_pd", pad_p3.pd, 8'h00);
      wr(6'h30, 8'h00);
      wr(6'h11, 8'hFF);
      rdc(6'h11, 8'h7F, "p5_dir");
      chk("p5_oe", pad_p5.oe, 8'h7F);
      wr(6'h29, 8'hFF);
      rdc(6'h29, 8'h7F, "pa_dir");
      wr(6'h19, 8'h0F);
      wr(6'h18, 8'h05);
      chk("p7_pins", pin_p7 & 8'h0F, 8'h05);
   endtask

   task t_osc;
      wr(6'h31, 8'h01);
      chk("osc_sel", {7'h00, osc_sel}, 8'h01);
      chk("p9_pu_off", pad_p9.pu, 8'h00);
      wr(6'h31, 8'h00);
      chk("p9_pu_on", pad_p9.pu, 8'h01);
      @(posedge sys_clk);
      ext_en <= 8'hFF;
      ext_drv <= 8'h5A;
      rdc(6'h05, 8'h5A, "p1_in");
      rdc(6'h25, 8'h00, "p9_in");
      @(posedge sys_clk);
      ext_en <= 8'h00;
   endtask

   task t_drive_modes;
      wr(6'h01, 8'h03);
      wr(6'h00, 8'h01);
      wr(6'h03, 8'h03);
      chk("od_oe", pad_p1.oe, 8'h02);
      chk("od_low", pin_p1 & 8'h02, 8'h00);
      wr(6'h03, 8'h00);
      chk("pp_oe", pad_p1.oe, 8'h03);
      @(posedge sys_clk);
      fn_v <= 8'h0F;
      wr(6'h00, 8'h00);
      wr(6'h01, 8'h05);
      wr(6'h04, 8'h03);
      chk("fn_oe", pad_p1.oe, 8'h05);
      chk("fn_o", pad_p1.o & 8'h05, 8'h01);
      @(posedge sys_clk);
      ser_v <= 8'h04;
      #1;
      chk("ser_o", pad_p1.o & 8'h05, 8'h05);
      @(posedge sys_clk);
      ser_v <= 8'h00;
      wr(6'h04, 8'h00);
      chk("latch_o", pad_p1.o & 8'h05, 8'h00);
   endtask

   task t_resets;
      wr(6'h32, 8'h00);
      chk("rst_oe", {rp_oe, rp_i, core_n, 5'h00}, 8'h80);
      wait_core(`MPPC_SWRST_CYC + `MPPC_STAB_CYC, "sw_wait");
      rdc(6'h01, 8'h05, "dir_kept");
      wr(6'h32, 8'h80);
      @(posedge sys_clk);
      ext_rst_n <= 1'b0;
      repeat (30) @(posedge sys_clk);
      #1;
      chk("pin_hold", {7'h00, core_n}, 8'h00);
      @(posedge sys_clk);
      ext_rst_n <= 1'b1;
      wait_core(`MPPC_STAB_CYC, "pin_wait");
      rdc(6'h3F, 8'h00, "unmapped");
      rdc(6'h33, 8'h02, "status");
   endtask

   initial
   begin
      repeat (20) @(posedge sys_clk);
      rstn <= 1'b1;
      t_reset_vals();
      t_dir_pull();
      t_narrow();
      t_osc();
      t_drive_modes();
      t_resets();
      end_of_test();
   end

   initial
   begin
      #100000;
      err_total++;
      end_of_test();
   end
endmodule
